// File: hdl/cond_branch_load_store_exec.sv
// Operation
// - A branch on a chosen flag bit being 0 sets the counter to counter plus offset plus one, in one or two clocks.
// - A branch on the nibble carry flag being 1 goes to counter plus offset plus one, in one or two clocks.
// - A branch on the nibble carry flag being 0 goes to counter plus offset plus one, in one or two clocks.
// - Branches on the bit-copy flag being 1 or 0 add offset plus one when taken, in one or two clocks.
// - Branches on the signed-wrap flag being 1 or 0 add offset plus one when taken, in one or two clocks.
// - Branches on the interrupt enable flag being 1 or 0 add offset plus one when taken, in one or two clocks.
// - Unsigned same-or-higher and carry-clear branch on borrow 0, unsigned lower on borrow 1.
// - Signed greater-or-equal branches when msb xor signed-wrap is 0.
// - Signed less-than branches when msb xor signed-wrap is 1.
// - Post-increment load reads at the pointer, then steps the pointer up by one, in two clocks.
// - Pre-decrement load steps the pointer down by one, then reads at it, in two clocks.
// - Displacement load reads at the second or third pointer plus an unsigned displacement, pointer kept.
// - Direct load reads at the absolute address given, in two clocks, flags untouched.
// - Post-increment store writes the source at the pointer, then steps the pointer up, in two clocks.
// - A branch on a chosen flag bit being 1 sets the counter to counter plus offset plus one.
`timescale 1ns/100ps

module cond_branch_load_store_exec
	import exec_pkg::*;
#(
	parameter int PC_W   = PC_WIDTH,
	parameter int ADDR_W = ADDR_WIDTH,
	parameter int DATA_W = DATA_WIDTH
)(
	input  wire logic                    mclk,
	input  wire logic                    nrst,
	input  wire logic                    start,
	input  wire exec_op_t                op,
	input  wire cond_t                   cond,
	input  wire logic [2:0]              flag_sel,
	input  wire logic [FLAG_WIDTH-1:0]   flag_register,
	input  wire logic [OFFSET_WIDTH-1:0] branch_offset,
	input  wire logic [PC_W-1:0]         pc_now,
	input  wire mem_mode_t               mode,
	input  wire ptr_t                    ptr_sel,
	input  wire logic [DISP_WIDTH-1:0]   disp,
	input  wire logic [ADDR_W-1:0]       abs_addr,
	input  wire logic [REG_IDX_W-1:0]    reg_idx,
	input  wire logic [ADDR_W-1:0]       ptr_x,
	input  wire logic [ADDR_W-1:0]       ptr_y,
	input  wire logic [ADDR_W-1:0]       ptr_z,
	input  wire logic [DATA_W-1:0]       source_register,
	input  wire logic [DATA_W-1:0]       mem_rdata,
	output logic                         busy,
	output logic                         done,
	output logic                         illegal,
	output logic                         pc_load,
	output logic      [PC_W-1:0]         pc_target,
	output logic                         mem_rd,
	output logic                         mem_wr,
	output logic      [ADDR_W-1:0]       mem_addr,
	output logic      [DATA_W-1:0]       mem_wdata,
	output logic                         reg_wr,
	output logic      [REG_IDX_W-1:0]    reg_wr_idx,
	output logic      [DATA_W-1:0]       reg_wr_data,
	output logic                         ptr_wr,
	output ptr_t                         ptr_wr_sel,
	output logic      [ADDR_W-1:0]       ptr_wr_value
);

	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	// the address unit and the package constants are fixed at these
	// widths, so other values cannot be served
	generate
		if (PC_W != PC_WIDTH || ADDR_W != ADDR_WIDTH
				|| DATA_W != DATA_WIDTH) begin : g_bad_width
			$error("widths must match the package widths");
		end
	endgenerate

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// pointer pair lookup, used for the read and for the write-back
	function automatic logic [ADDR_W-1:0] pick_pointer(
		input ptr_t             sel,
		input logic [ADDR_W-1:0] px,
		input logic [ADDR_W-1:0] py,
		input logic [ADDR_W-1:0] pz
	);
		case (sel)
			PTR_X:   pick_pointer = px;
			PTR_Y:   pick_pointer = py;
			PTR_Z:   pick_pointer = pz;
			default: pick_pointer = px;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// state and latched command
	// ---------------------------------------------------------------
	state_t                state;
	state_t                next_state;
	exec_op_t              lat_op;
	logic [REG_IDX_W-1:0]  lat_reg_idx;
	ptr_t                  lat_ptr_sel;
	logic [ADDR_W-1:0]     lat_new_ptr;
	logic                  lat_ptr_changes;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	logic                  take;
	logic [ADDR_W-1:0]     eff_addr;
	logic [ADDR_W-1:0]     new_ptr;
	logic                  ptr_changes;

	wire idle       = (state == ST_IDLE);
	wire finishing  = (state == ST_FINISH);
	wire accept     = start && idle;
	wire is_branch  = (op == OP_BRANCH);
	wire is_load    = (op == OP_LOAD);
	wire is_store   = (op == OP_STORE);
	wire uses_ptr   = (mode != MODE_ABS);
	wire ptr_known  = (ptr_sel != PTR_NONE);
	// displacement only rides on the second and third pairs
	wire disp_ok    = (mode != MODE_DISP) || (ptr_sel != PTR_X);
	wire load_ok    = is_load && disp_ok
		&& (ptr_known || !uses_ptr);
	// other store forms belong to another block
	wire store_ok   = is_store && ptr_known
		&& (mode == MODE_PLAIN || mode == MODE_POSTINC);
	wire legal      = is_branch || load_ok || store_ok;
	wire mem_go     = accept && (load_ok || store_ok);
	// of the branches, only a taken one needs a second clock
	wire br_taken   = accept && is_branch && take;
	wire br_skip    = accept && is_branch && !take;
	wire bad_cmd    = accept && !legal;

	wire [ADDR_W-1:0] ptr_value = pick_pointer(ptr_sel, ptr_x,
		ptr_y, ptr_z);

	// signed word offset, sign extended to the counter width
	wire [PC_W-1:0] offset_ext = {{(PC_W-OFFSET_WIDTH)
		{branch_offset[OFFSET_WIDTH-1]}}, branch_offset};
	// target is counter plus offset plus one
	wire [PC_W-1:0] target = pc_now + offset_ext + PC_STEP;

	// ---------------------------------------------------------------
	// sub-blocks
	// ---------------------------------------------------------------
	// condition check; flags are an input only
	flag_condition u_flag_condition (
		.cond          (cond),
		.flag_sel      (flag_sel),
		.flag_register (flag_register),
		.take          (take)
	);

	// effective address and pointer write-back value
	address_unit u_address_unit (
		.mode        (mode),
		.ptr_value   (ptr_value),
		.disp        (disp),
		.abs_addr    (abs_addr),
		.eff_addr    (eff_addr),
		.new_ptr     (new_ptr),
		.ptr_changes (ptr_changes)
	);

	// ---------------------------------------------------------------
	// sequencing
	// ---------------------------------------------------------------
	// two-state walk; finish always returns to idle
	always_comb begin
		case (state)
			ST_IDLE:   next_state = (br_taken || mem_go)
				? ST_FINISH : ST_IDLE;
			ST_FINISH: next_state = ST_IDLE;
			default:   next_state = ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// latch what the second clock needs
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lat_op          <= OP_NONE;
			lat_reg_idx     <= '0;
			lat_ptr_sel     <= PTR_X;
			lat_new_ptr     <= ADDR_RST;
			lat_ptr_changes <= 1'b0;
		end else if (accept) begin
			lat_op          <= legal ? op : OP_NONE;
			lat_reg_idx     <= reg_idx;
			lat_ptr_sel     <= ptr_sel;
			lat_new_ptr     <= new_ptr;
			lat_ptr_changes <= ptr_changes;
		end
	end

	// ---------------------------------------------------------------
	// handshake outputs
	// ---------------------------------------------------------------
	// done closes every accepted command, legal or not
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			busy    <= 1'b0;
			done    <= 1'b0;
			illegal <= 1'b0;
		end else begin
			busy    <= (next_state != ST_IDLE);
			// untaken branch ends after one clock
			done    <= br_skip || bad_cmd || finishing;
			illegal <= bad_cmd;
		end
	end

	// ---------------------------------------------------------------
	// program counter
	// ---------------------------------------------------------------
	// target captured at accept, so a pc_now change later is harmless
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pc_target <= PC_RST;
			pc_load   <= 1'b0;
		end else begin
			if (br_taken) begin
				pc_target <= target;
			end
			pc_load <= finishing && (lat_op == OP_BRANCH);
		end
	end

	// ---------------------------------------------------------------
	// data memory
	// ---------------------------------------------------------------
	// address and strobes go out in the first clock
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mem_rd    <= 1'b0;
			mem_wr    <= 1'b0;
			mem_addr  <= ADDR_RST;
			mem_wdata <= DATA_RST;
		end else begin
			// read strobe for every load form
			mem_rd <= mem_go && is_load;
			// store writes in its first clock
			mem_wr <= mem_go && is_store;
			if (mem_go) begin
				mem_addr  <= eff_addr;
				mem_wdata <= source_register;
			end
		end
	end

	// ---------------------------------------------------------------
	// register file and pointer write-back
	// ---------------------------------------------------------------
	// read data is taken at the end of the strobe cycle, so memory
	// must answer within that cycle
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			reg_wr      <= 1'b0;
			reg_wr_idx  <= '0;
			reg_wr_data <= DATA_RST;
		end else begin
			reg_wr <= finishing && (lat_op == OP_LOAD);
			if (finishing && (lat_op == OP_LOAD)) begin
				reg_wr_idx  <= lat_reg_idx;
				reg_wr_data <= mem_rdata;
			end
		end
	end

	// pointer step lands with the end of the command
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ptr_wr       <= 1'b0;
			ptr_wr_sel   <= PTR_X;
			ptr_wr_value <= ADDR_RST;
		end else begin
			ptr_wr <= finishing && lat_ptr_changes
				&& (lat_op == OP_LOAD || lat_op == OP_STORE);
			if (finishing) begin
				ptr_wr_sel   <= lat_ptr_sel;
				ptr_wr_value <= lat_new_ptr;
			end
		end
	end

endmodule // cond_branch_load_store_exec

// File: hdl/exec_pkg.sv
package exec_pkg;

	// ---------------------------------------------------------------
	// widths and counts
	// ---------------------------------------------------------------
	localparam int PC_WIDTH     = 16;
	localparam int ADDR_WIDTH   = 16;
	localparam int DATA_WIDTH   = 8;
	localparam int OFFSET_WIDTH = 7;
	localparam int DISP_WIDTH   = 6;
	localparam int REG_IDX_W    = 5;
	localparam int FLAG_WIDTH   = 8;
	localparam int BRANCH_SLOW_CLOCKS = 2; // taken branch
	localparam int BRANCH_FAST_CLOCKS = 1; // branch falls through
	localparam int MEMORY_CLOCKS      = 2; // every load and store

	// ---------------------------------------------------------------
	// flag register bit positions
	// ---------------------------------------------------------------
	localparam logic [2:0] FLAG_CARRY     = 3'h0;
	localparam logic [2:0] FLAG_NIL       = 3'h1;
	localparam logic [2:0] FLAG_MSB       = 3'h2;
	localparam logic [2:0] FLAG_WRAP      = 3'h3;
	localparam logic [2:0] FLAG_SIGN      = 3'h4;
	localparam logic [2:0] FLAG_NIBBLE    = 3'h5;
	localparam logic [2:0] FLAG_BITCOPY   = 3'h6;
	localparam logic [2:0] FLAG_INT_EN    = 3'h7;

	// ---------------------------------------------------------------
	// pointer steps and reset values
	// ---------------------------------------------------------------
	localparam logic [ADDR_WIDTH-1:0] PTR_STEP = 16'h0001;
	localparam logic [PC_WIDTH-1:0]   PC_STEP  = 16'h0001;
	localparam logic [ADDR_WIDTH-1:0] ADDR_RST = 16'h0000;
	localparam logic [PC_WIDTH-1:0]   PC_RST   = 16'h0000;
	localparam logic [DATA_WIDTH-1:0] DATA_RST = 8'h00;

	// ---------------------------------------------------------------
	// command encodings
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_BRANCH = 2'h0,
		OP_LOAD   = 2'h1,
		OP_STORE  = 2'h2,
		OP_NONE   = 2'h3
	} exec_op_t;

	typedef enum logic [4:0] {
		COND_FLAG_CLR = 5'h00, COND_FLAG_SET = 5'h01,
		COND_EQ       = 5'h02, COND_NE       = 5'h03,
		COND_CS       = 5'h04, COND_CC       = 5'h05,
		COND_US_GE    = 5'h06, COND_US_LESS  = 5'h07,
		COND_MI       = 5'h08, COND_PL       = 5'h09,
		COND_S_GE     = 5'h0A, COND_S_LESS   = 5'h0B,
		COND_HS       = 5'h0C, COND_HC       = 5'h0D,
		COND_TS       = 5'h0E, COND_TC       = 5'h0F,
		COND_VS       = 5'h10, COND_VC       = 5'h11,
		COND_IE       = 5'h12, COND_ID       = 5'h13
	} cond_t;

	typedef enum logic [2:0] {
		MODE_PLAIN   = 3'h0,
		MODE_POSTINC = 3'h1,
		MODE_PREDEC  = 3'h2,
		MODE_DISP    = 3'h3,
		MODE_ABS     = 3'h4
	} mem_mode_t;

	typedef enum logic [1:0] {
		PTR_X = 2'h0,
		PTR_Y = 2'h1,
		PTR_Z = 2'h2,
		PTR_NONE = 2'h3
	} ptr_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_FINISH = 2'h1
	} state_t;

endpackage

// File: hdl/flag_condition.sv
`timescale 1ns/100ps

module flag_condition
	import exec_pkg::*;
(
	input  wire cond_t                 cond,
	input  wire logic [2:0]            flag_sel,
	input  wire logic [FLAG_WIDTH-1:0] flag_register,
	output logic                       take
);

	// ---------------------------------------------------------------
	// named flags
	// ---------------------------------------------------------------
	wire sel_bit = flag_register[flag_sel];
	wire c_flag  = flag_register[FLAG_CARRY];
	wire z_flag  = flag_register[FLAG_NIL];
	wire n_flag  = flag_register[FLAG_MSB];
	wire v_flag  = flag_register[FLAG_WRAP];
	wire h_flag  = flag_register[FLAG_NIBBLE];
	wire t_flag  = flag_register[FLAG_BITCOPY];
	wire i_flag  = flag_register[FLAG_INT_EN];
	// signed order uses n xor v, not the stored sign bit, on purpose
	wire nv_diff = n_flag ^ v_flag;

	// condition select; flags are only read here, never written
	always_comb begin
		case (cond)
			COND_FLAG_CLR: take = ~sel_bit;
			COND_FLAG_SET: take = sel_bit;
			COND_EQ:       take = z_flag;
			COND_NE:       take = ~z_flag;
			COND_MI:       take = n_flag;
			COND_PL:       take = ~n_flag;
			COND_CS:       take = c_flag;
			COND_US_LESS:  take = c_flag;
			COND_CC:       take = ~c_flag;
			COND_US_GE:    take = ~c_flag;
			COND_S_GE:     take = ~nv_diff;
			COND_S_LESS:   take = nv_diff;
			COND_HS:       take = h_flag;
			COND_HC:       take = ~h_flag;
			COND_TS:       take = t_flag;
			COND_TC:       take = ~t_flag;
			COND_VS:       take = v_flag;
			COND_VC:       take = ~v_flag;
			COND_IE:       take = i_flag;
			COND_ID:       take = ~i_flag;
			default:       take = 1'b0;
		endcase
	end

endmodule // flag_condition

// File: hdl/address_unit.sv
`timescale 1ns/100ps

module address_unit
	import exec_pkg::*;
(
	input  wire mem_mode_t             mode,
	input  wire logic [ADDR_WIDTH-1:0] ptr_value,
	input  wire logic [DISP_WIDTH-1:0] disp,
	input  wire logic [ADDR_WIDTH-1:0] abs_addr,
	output logic      [ADDR_WIDTH-1:0] eff_addr,
	output logic      [ADDR_WIDTH-1:0] new_ptr,
	output logic                       ptr_changes
);

	// ---------------------------------------------------------------
	// pointer arithmetic
	// ---------------------------------------------------------------
	wire [ADDR_WIDTH-1:0] ptr_inc  = ptr_value + PTR_STEP;
	wire [ADDR_WIDTH-1:0] ptr_dec  = ptr_value - PTR_STEP;
	// displacement is unsigned, so zero extend
	wire [ADDR_WIDTH-1:0] ptr_disp = ptr_value
		+ {{(ADDR_WIDTH-DISP_WIDTH){1'b0}}, disp};

	// address and write-back per mode
	always_comb begin
		case (mode)
			MODE_POSTINC: begin
				eff_addr    = ptr_value;
				new_ptr     = ptr_inc;
				ptr_changes = 1'b1;
			end
			MODE_PREDEC: begin
				eff_addr    = ptr_dec;
				new_ptr     = ptr_dec;
				ptr_changes = 1'b1;
			end
			MODE_DISP: begin
				eff_addr    = ptr_disp;
				new_ptr     = ptr_value;
				ptr_changes = 1'b0;
			end
			MODE_ABS: begin
				eff_addr    = abs_addr;
				new_ptr     = ptr_value;
				ptr_changes = 1'b0;
			end
			default: begin
				eff_addr    = ptr_value;
				new_ptr     = ptr_value;
				ptr_changes = 1'b0;
			end
		endcase
	end

endmodule // address_unit

// File: verif/cond_exec_assertions.sv
`timescale 1ns/100ps

module cond_exec_checker
	import exec_pkg::*;
#(
	parameter int PC_W   = PC_WIDTH,
	parameter int ADDR_W = ADDR_WIDTH,
	parameter int DATA_W = DATA_WIDTH
)(
	input wire logic                    mclk,
	input wire logic                    nrst,
	input wire logic                    start,
	input wire exec_op_t                op,
	input wire cond_t                   cond,
	input wire logic [2:0]              flag_sel,
	input wire logic [FLAG_WIDTH-1:0]   flag_register,
	input wire logic [OFFSET_WIDTH-1:0] branch_offset,
	input wire logic [PC_W-1:0]         pc_now,
	input wire mem_mode_t               mode,
	input wire ptr_t                    ptr_sel,
	input wire logic [DISP_WIDTH-1:0]   disp,
	input wire logic [ADDR_W-1:0]       abs_addr,
	input wire logic [ADDR_W-1:0]       ptr_x,
	input wire logic [ADDR_W-1:0]       ptr_y,
	input wire logic [ADDR_W-1:0]       ptr_z,
	input wire logic [DATA_W-1:0]       source_register,
	input wire logic [DATA_W-1:0]       mem_rdata,
	input wire logic                    busy,
	input wire logic                    done,
	input wire logic                    illegal,
	input wire logic                    pc_load,
	input wire logic [PC_W-1:0]         pc_target,
	input wire logic                    mem_rd,
	input wire logic                    mem_wr,
	input wire logic [ADDR_W-1:0]       mem_addr,
	input wire logic [DATA_W-1:0]       mem_wdata,
	input wire logic                    reg_wr,
	input wire logic [DATA_W-1:0]       reg_wr_data,
	input wire logic                    ptr_wr,
	input wire logic [ADDR_W-1:0]       ptr_wr_value
);
	// ------------------------------
	// helper logic
	// ------------------------------
	// a command is taken only while idle
	wire accept = start && !busy;
	wire ld     = accept && op == OP_LOAD;
	wire br     = accept && op == OP_BRANCH;
	logic [PC_W-1:0] exp_target;

	// target kept from the accept edge, so a busy cycle cannot disturb it
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			exp_target <= '0;
		else if (accept)
			exp_target <= pc_now + PC_STEP + {{(PC_W-OFFSET_WIDTH)
				{branch_offset[OFFSET_WIDTH-1]}}, branch_offset};
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	// ------------------------------
	// properties
	// ------------------------------
	// target sum
	property p_target;
		pc_load |-> done && !illegal && pc_target == exp_target;
	endproperty
	a_target: assert property (p_target)
		else $error("branch target differs from counter plus offset");
	property p_set_taken;
		br && cond == COND_FLAG_SET && flag_register[flag_sel]
			|=> busy && !done ##1 pc_load && done;
	endproperty
	a_set_taken: assert property (p_set_taken)
		else $error("taken branch did not finish in two clocks");
	property p_clr_untaken;
		br && cond == COND_FLAG_CLR && flag_register[flag_sel]
			|=> done && !busy && !pc_load;
	endproperty
	a_clr_untaken: assert property (p_clr_untaken)
		else $error("untaken branch did not fall through in one clock");
	property p_postinc;
		ld && mode == MODE_POSTINC && ptr_sel == PTR_X
			|=> mem_rd && mem_addr == $past(ptr_x)
			##1 done && ptr_wr && ptr_wr_value == $past(ptr_x, 2) + PTR_STEP;
	endproperty
	a_postinc: assert property (p_postinc)
		else $error("post-increment load wrong");
	property p_predec;
		ld && mode == MODE_PREDEC && ptr_sel == PTR_Y
			|=> mem_rd && mem_addr == $past(ptr_y) - PTR_STEP
			##1 ptr_wr && ptr_wr_value == $past(ptr_y, 2) - PTR_STEP;
	endproperty
	a_predec: assert property (p_predec)
		else $error("pre-decrement load wrong");
	property p_disp;
		ld && mode == MODE_DISP && ptr_sel == PTR_Z
			|=> mem_rd && !ptr_wr && mem_addr == $past(ptr_z) + $past(disp)
			##1 done && !ptr_wr;
	endproperty
	a_disp: assert property (p_disp)
		else $error("displacement load wrong");
	property p_abs;
		ld && mode == MODE_ABS
			|=> mem_rd && mem_addr == $past(abs_addr) ##1 reg_wr && !ptr_wr;
	endproperty
	a_abs: assert property (p_abs)
		else $error("direct load wrong");
	property p_regdata;
		reg_wr |-> done && reg_wr_data == $past(mem_rdata);
	endproperty
	a_regdata: assert property (p_regdata)
		else $error("loaded byte differs from memory data");
	property p_store;
		accept && op == OP_STORE && mode == MODE_POSTINC && ptr_sel == PTR_Z
			|=> mem_wr && !mem_rd && mem_addr == $past(ptr_z)
			&& mem_wdata == $past(source_register)
			##1 done && ptr_wr && ptr_wr_value == $past(ptr_z, 2) + PTR_STEP;
	endproperty
	a_store: assert property (p_store)
		else $error("post-increment store wrong");

	c_taken: cover property (pc_load);
	c_step: cover property (mem_rd ##1 ptr_wr);
	c_refused: cover property (illegal);
endmodule // cond_exec_checker

bind cond_branch_load_store_exec cond_exec_checker #(.PC_W(PC_W),
	.ADDR_W(ADDR_W), .DATA_W(DATA_W)) check_inst (.mclk, .nrst, .start,
	.op, .cond, .flag_sel, .flag_register, .branch_offset, .pc_now, .mode,
	.ptr_sel, .disp, .abs_addr, .ptr_x, .ptr_y, .ptr_z, .source_register,
	.mem_rdata, .busy, .done, .illegal, .pc_load, .pc_target, .mem_rd,
	.mem_wr, .mem_addr, .mem_wdata, .reg_wr, .reg_wr_data, .ptr_wr,
	.ptr_wr_value);

// File: verif/tb.sv
`timescale 1ns/100ps

module tb
	import exec_pkg::*;
;
	// ------------------------------
	// stimulus and observation
	// ------------------------------
	logic        mclk = 1'b0, nrst = 1'b0, start = 1'b0;
	exec_op_t    op = OP_NONE;
	cond_t       cond = COND_FLAG_CLR;
	mem_mode_t   mode = MODE_PLAIN;
	ptr_t        ptr_sel = PTR_X;
	logic [2:0]  flag_sel = 3'h0;
	logic [4:0]  reg_idx = 5'h00;
	logic [5:0]  disp = 6'h3F;
	logic [6:0]  branch_offset = 7'h00;
	logic [7:0]  flag_register = 8'h00, source_register = 8'h00;
	logic [7:0]  mem_rdata = 8'h00;
	logic [15:0] pc_now = 16'h0000, abs_addr = 16'hBEEF;
	logic [15:0] ptr_x = 16'hFFFF, ptr_y = 16'h0000, ptr_z = 16'h1234;
	logic        busy, done, illegal, pc_load, mem_rd, mem_wr, reg_wr, ptr_wr;
	logic [4:0]  reg_wr_idx;
	logic [7:0]  mem_wdata, reg_wr_data;
	logic [15:0] pc_target, mem_addr, ptr_wr_value;
	ptr_t        ptr_wr_sel;
	int          n_done, first, n_pc, n_rd, n_wr, n_reg, n_ptr, n_ill;
	int          fail_count = 0, comparisons = 0, cycles = 0;

	cond_branch_load_store_exec cond_branch_load_store_exec_inst (.mclk,
		.nrst, .start, .op, .cond, .flag_sel, .flag_register,
		.branch_offset, .pc_now, .mode, .ptr_sel, .disp, .abs_addr, .reg_idx,
		.ptr_x, .ptr_y, .ptr_z, .source_register, .mem_rdata, .busy, .done,
		.illegal, .pc_load, .pc_target, .mem_rd, .mem_wr, .mem_addr,
		.mem_wdata, .reg_wr, .reg_wr_idx, .reg_wr_data, .ptr_wr, .ptr_wr_sel,
		.ptr_wr_value);

	// 10 MHz core clock
	always #50 mclk = ~mclk;

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			finish_test;
		end
	end

	task automatic check_eq(input logic [15:0] got, exp, input string what);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask

	// raise start for hold edges, then count strobes over five cycles
	task automatic fire(input int hold);
		{n_done, first, n_pc, n_rd, n_wr, n_reg, n_ptr, n_ill} = '0;
		start <= 1'b1;
		for (int i = 1; i <= 5; i++) begin
			@(posedge mclk);
			if (i == hold)
				start <= 1'b0;
			@(negedge mclk);
			if (done === 1'b1 && first == 0)
				first = i;
			n_done += int'(done === 1'b1);
			n_pc += int'(pc_load === 1'b1);
			n_rd += int'(mem_rd === 1'b1);
			n_wr += int'(mem_wr === 1'b1);
			n_reg += int'(reg_wr === 1'b1);
			n_ptr += int'(ptr_wr === 1'b1);
			n_ill += int'(illegal === 1'b1);
		end
	endtask

	function automatic logic taken_of(cond_t c, logic [7:0] f, logic [2:0] s);
		case (c)
			COND_FLAG_CLR: return !f[s];
			COND_FLAG_SET: return f[s];
			COND_EQ: return f[FLAG_NIL];
			COND_NE: return !f[FLAG_NIL];
			COND_CS, COND_US_LESS: return f[FLAG_CARRY];
			COND_CC, COND_US_GE: return !f[FLAG_CARRY];
			COND_MI: return f[FLAG_MSB];
			COND_PL: return !f[FLAG_MSB];
			COND_S_GE: return !(f[FLAG_MSB] ^ f[FLAG_WRAP]);
			COND_S_LESS: return f[FLAG_MSB] ^ f[FLAG_WRAP];
			COND_HS: return f[FLAG_NIBBLE];
			COND_HC: return !f[FLAG_NIBBLE];
			COND_TS: return f[FLAG_BITCOPY];
			COND_TC: return !f[FLAG_BITCOPY];
			COND_VS: return f[FLAG_WRAP];
			COND_VC: return !f[FLAG_WRAP];
			COND_IE: return f[FLAG_INT_EN];
			COND_ID: return !f[FLAG_INT_EN];
			default: return 1'b0;
		endcase
	endfunction

	// every condition against four flag patterns; offsets of both signs, no checked target wraps the counter
	task automatic test_branches;
		logic [7:0]  fl [4];
		logic        t;
		logic [15:0] tgt;
		fl = '{8'h00, 8'hFF, 8'h04, 8'h5A};
		for (int c = 0; c < 20; c++) begin
			for (int j = 0; j < 4; j++) begin
				@(posedge mclk);
				op <= OP_BRANCH;
				cond <= cond_t'(c);
				flag_sel <= 3'(c + j);
				flag_register <= fl[j];
				branch_offset <= 7'(c * 9 + j * 37);
				pc_now <= 16'(c * 3121);
				fire(1);
				t = taken_of(cond, flag_register, flag_sel);
				tgt = pc_now + {{9{branch_offset[6]}}, branch_offset} + 16'h0001;
				check_eq(16'(first), t ? 16'h2 : 16'h1, "clocks");
				check_eq(16'(n_pc), 16'(t), "taken");
				if (t)
					check_eq(pc_target, tgt, "target");
				check_eq(16'(n_rd + n_wr + n_ptr + n_ill + n_reg), 16'h0,
					"extra");
			end
		end
		$display("test_branches finished");
	endtask

	// load forms at pointer edges, then refused forms: first-pair
	// displacement and the empty command
	task automatic test_loads;
		mem_mode_t   md [5];
		ptr_t        ps [5];
		logic [15:0] ea [5];
		logic [15:0] pv [2];
		md = '{MODE_POSTINC, MODE_PREDEC, MODE_DISP, MODE_DISP, MODE_ABS};
		ps = '{PTR_X, PTR_Y, PTR_Y, PTR_Z, PTR_NONE};
		ea = '{16'hFFFF, 16'hFFFF, 16'h003F, 16'h1273, 16'hBEEF};
		pv = '{16'h0000, 16'hFFFF};
		for (int k = 0; k < 7; k++) begin
			@(posedge mclk);
			op <= (k == 6) ? OP_NONE : OP_LOAD;
			mode <= (k < 5) ? md[k] : MODE_DISP;
			ptr_sel <= (k < 5) ? ps[k] : PTR_X;
			reg_idx <= 5'(k * 7 + 3);
			mem_rdata <= 8'(8'hA5 + k * 23);
			fire(1);
			if (k > 4) begin
				// refusal: done after one clock, no read, no register write
				check_eq(16'(first * 8 + n_ill * 4 + n_rd * 2 + n_reg),
					16'hC, "refused");
			end else begin
				check_eq(16'(first), 16'h2, "clocks");
				check_eq(16'(n_rd), 16'h1, "read");
				check_eq(16'(n_reg), 16'h1, "reg write");
				check_eq(mem_addr, ea[k], "addr");
				check_eq(16'(reg_wr_data), 16'(mem_rdata), "data");
				check_eq(16'(reg_wr_idx), 16'(reg_idx), "index");
				check_eq(16'(n_ptr), 16'(k < 2), "ptr write");
				if (k < 2) begin
					check_eq(ptr_wr_value, pv[k], "ptr");
					check_eq(16'(ptr_wr_sel), 16'(ps[k]), "ptr sel");
				end
			end
		end
		$display("test_loads finished");
	endtask

	// second store holds start into its busy cycle, which must be ignored
	task automatic test_stores;
		for (int k = 0; k < 2; k++) begin
			@(posedge mclk);
			op <= OP_STORE;
			mode <= (k == 0) ? MODE_POSTINC : MODE_PLAIN;
			ptr_sel <= (k == 0) ? PTR_Z : PTR_X;
			source_register <= 8'(8'h3C + k * 65);
			fire(k + 1);
			check_eq(16'(first), 16'h2, "clocks");
			check_eq(16'(n_done), 16'h1, "one command");
			check_eq(16'(n_wr + n_rd * 2 + n_reg * 4), 16'h1, "write");
			check_eq(mem_addr, k ? 16'hFFFF : 16'h1234, "addr");
			check_eq(16'(mem_wdata), 16'(source_register), "data");
			check_eq(16'(n_ptr), 16'(k == 0), "ptr write");
			if (k == 0)
				check_eq(ptr_wr_value, 16'h1235, "ptr");
		end
		$display("test_stores finished");
	endtask

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// reset for twelve cycles, then the scenarios in turn
	initial begin
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		test_branches;
		test_loads;
		test_stores;
		finish_test;
	end
endmodule // tb
